// File: hw/eepc_pkg.sv
/*
 * Shared constants for the nonvolatile program/erase controller:
 * register offsets, control bit positions, reset values, timing.
 * Assumes a 40 MHz system clock and byte addresses on a 12-bit bus.
 */
package eepc_pkg;
   // Bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTL = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_GUARD = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_OPT = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_STAT = 12'h00c;
   localparam logic [ADDR_W-1:0] OFS_CFG = 12'h010;
   // Address bit that selects the array window (0x800..0xffc)
   localparam int ARRAY_SEL_BIT = 11;

   // program_erase_control bit positions
   localparam int PVE_BIT = 0;
   localparam int NVL_BIT = 1;
   localparam int ERASE_BIT = 2;
   localparam int ROW_BIT = 3;
   localparam int BYTE_BIT = 4;
   localparam int OTPL_BIT = 5;
   localparam int EVEN_BIT = 6;
   localparam int ODD_BIT = 7;
   localparam logic [7:0] CTL_RESET = 8'h00;

   // block_write_guard: bits 3:0 array quarters, bit 4 setup cell
   localparam int GUARD_W = 5;
   localparam int GUARD_CFG_BIT = 4;
   localparam logic [GUARD_W-1:0] GUARD_RESET = 5'h1f;

   // Array shape and data values
   localparam int ARRAY_BYTES = 512;
   localparam int ROW_BYTES = 16;
   localparam logic [7:0] ERASED = 8'hff;
   localparam logic [7:0] LOCKED_READ = 8'h00;

   // Program/erase high-voltage time
   localparam int PROG_TIME_US = 10000;
   localparam int CLK_MHZ = 40;
   localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;

   // Status register bits
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_TGT_BIT = 2;
   localparam int STAT_SEC_BIT = 3;

   typedef enum logic [2:0] {
      ENG_IDLE = 3'b000,
      ENG_ARMED = 3'b001,
      ENG_RD = 3'b010,
      ENG_WR = 3'b011,
      ENG_WALK = 3'b100
   } eepc_eng_e;
endpackage

// File: hw/eepc_mem_if.sv
/*
 * Byte memory port between the controller and its array.
 * Assumes one clock; read data appear one edge after the address.
 */
interface eepc_mem_if #(
   parameter int AW = 9
);
   logic [AW-1:0] addr;
   logic we;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport user (output addr, output we, output wdata, input rdata);
   modport mem (input addr, input we, input wdata, output rdata);
endinterface

// File: hw/eepc_byte_mem.sv
/*
 * Byte-wide array store with registered read data.
 * Assumes the controller only writes while high voltage is applied.
 */
module eepc_byte_mem #(
   parameter int AW = 9
) (
   // Clock
   input wire logic sys_clk_i,
   // Array port
   eepc_mem_if.mem mp
);
   typedef struct packed {
      logic [7:0] rdata;
   } eepc_mst_s;

   // Contents are nonvolatile, so they carry no reset
   logic [7:0] cells [2**AW];
   eepc_mst_s st;
   eepc_mst_s next_st;

   if (AW < 4) begin
      $error("eepc_byte_mem: AW too small");
   end

   always_comb begin
      next_st = st;
      next_st.rdata = cells[mp.addr];
   end

   always_ff @(posedge sys_clk_i) begin
      st <= next_st;
      if (mp.we) begin
         cells[mp.addr] <= mp.wdata;
      end
   end

   assign mp.rdata = st.rdata;
endmodule

// File: hw/eepc_delay.sv
/*
 * Programming-time counter: runs while run_i is high and gives one
 * pulse after CYCLES clocks. Dropping run_i restarts it.
 */
module eepc_delay #(
   parameter int CYCLES = 400000
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Control
   input wire logic run_i,
   output logic expired_o
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic fired;
      logic pulse;
   } eepc_dst_s;

   eepc_dst_s st;
   eepc_dst_s next_st;

   if (CYCLES < 1) begin
      $error("eepc_delay: CYCLES must be at least 1");
   end

   always_comb begin
      next_st = st;
      next_st.pulse = 1'b0;
      if (!run_i) begin
         next_st.cnt = '0;
         next_st.fired = 1'b0;
      end else if (!st.fired) begin
         if (st.cnt == LAST) begin
            next_st.fired = 1'b1;
            next_st.pulse = 1'b1;
         end else begin
            next_st.cnt = st.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign expired_o = st.pulse;
endmodule

// File: hw/eepc_ctrl.sv
/*
 * Nonvolatile array program/erase controller with an Avalon-MM slave.
 * Holds the control register, write guard, pump clock option, the
 * setup cell and the engine that applies a latched program or erase
 * once the high voltage has been on for the programming time.
 * Assumes a 40 MHz clock and a master that honours waitrequest.
 */
// Added by the designer: the address map and the Avalon-MM slave port.
module eepc_ctrl #(
   parameter int PROG_CYC = eepc_pkg::PROG_CYCLES,
   parameter int AW = 9
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Avalon-MM slave
   input wire logic [eepc_pkg::ADDR_W-1:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [3:0] byteenable_i,
   input wire logic [eepc_pkg::DATA_W-1:0] writedata_i,
   output logic [eepc_pkg::DATA_W-1:0] readdata_o,
   output logic waitrequest_o,
   // Security strap, asynchronous
   input wire logic secure_i,
   // Array and system controls
   output logic pump_voltage_o,
   output logic otp_program_path_o,
   output logic nv_program_path_o,
   output logic pump_clock_select_o,
   output logic single_chip_only_o,
   output logic [7:0] setup_cell_o
);
   import eepc_pkg::*;
   typedef struct packed {
      logic [7:0] ctl;
      logic [GUARD_W-1:0] guard;
      logic pump_sel;
      logic [7:0] cfg;
      logic tgt_valid;
      logic tgt_cfg;
      logic [AW-1:0] tgt_idx;
      logic [7:0] tgt_data;
      eepc_eng_e eng;
      logic op_erase;
      logic [AW-1:0] walk;
      logic [AW-1:0] walk_end;
      logic done;
      logic [1:0] rd_ph;
      logic [DATA_W-1:0] rdata;
      logic sec_s1;
      logic sec_s2;
      logic pve_q;
   } eepc_cst_s;

   localparam int RB = $clog2(ROW_BYTES);

   eepc_cst_s st;
   eepc_cst_s next_st;
   eepc_mem_if #(.AW(AW)) mif ();
   logic expired;
   logic wr;
   logic is_arr;
   logic [AW-1:0] idx;
   logic [7:0] w;
   logic [7:0] c;
   logic [DATA_W-1:0] rd_value;
   logic lat_ok;
   logic new_otp;
   logic new_nv;
   logic dual;

   if (AW + 2 > ARRAY_SEL_BIT || AW < RB + 2) begin
      $error("eepc_ctrl: AW does not fit the array window");
   end

   eepc_byte_mem #(.AW(AW)) u_mem (
      .sys_clk_i(sys_clk_i),
      .mp(mif.mem)
   );

   eepc_delay #(.CYCLES(PROG_CYC)) u_delay (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .run_i(st.eng == ENG_ARMED),
      .expired_o(expired)
   );

   function automatic logic guarded(input logic [GUARD_W-1:0] g,
                                    input logic [AW-1:0] a);
      guarded = g[a[AW-1 -: 2]];
   endfunction

   assign wr = write_i && byteenable_i[0];
   assign is_arr = address_i[ARRAY_SEL_BIT];
   assign idx = address_i[AW+1:2];
   assign w = writedata_i[7:0];
   assign c = st.ctl;

   // Read value; a latched array reads as a fixed pattern
   always_comb begin
      rd_value = '0;
      if (is_arr) begin
         rd_value[7:0] = c[NVL_BIT] ? LOCKED_READ : mif.rdata;
      end else begin
         case (address_i)
            OFS_CTL: rd_value[7:0] = c;
            OFS_GUARD: rd_value[GUARD_W-1:0] = st.guard;
            OFS_OPT: rd_value[0] = st.pump_sel;
            OFS_STAT: begin
               rd_value[STAT_BUSY_BIT] = st.eng != ENG_IDLE;
               rd_value[STAT_DONE_BIT] = st.done;
               rd_value[STAT_TGT_BIT] = st.tgt_valid;
               rd_value[STAT_SEC_BIT] = st.sec_s2;
            end
            OFS_CFG: rd_value[7:0] = c[NVL_BIT] ? LOCKED_READ : st.cfg;
            default: rd_value = '0;
         endcase
      end
   end

   // Control write filtering
   always_comb begin
      // Latches may only move while voltage is off or being removed
      lat_ok = !c[PVE_BIT] || !w[PVE_BIT];
      new_otp = lat_ok ? w[OTPL_BIT] : c[OTPL_BIT];
      new_nv = lat_ok ? w[NVL_BIT] : c[NVL_BIT];
      // Setting a latch and the voltage in one write is refused
      dual = w[PVE_BIT] && ((w[NVL_BIT] && !c[NVL_BIT]) ||
                            (w[OTPL_BIT] && !c[OTPL_BIT]));
   end

   always_comb begin
      next_st = st;
      mif.addr = idx;
      mif.we = 1'b0;
      mif.wdata = ERASED;
      next_st.sec_s1 = secure_i;
      next_st.sec_s2 = st.sec_s1;
      next_st.pve_q = c[PVE_BIT];

      // Reads take three edges: address, capture, answer
      if (read_i) begin
         case (st.rd_ph)
            2'd0: next_st.rd_ph = 2'd1;
            2'd1: begin
               next_st.rd_ph = 2'd2;
               next_st.rdata = rd_value;
            end
            default: next_st.rd_ph = 2'd0;
         endcase
      end

      if (wr && !is_arr && address_i == OFS_CTL) begin
         // Test row bits and extent bits are plain storage
         next_st.ctl[ODD_BIT] = w[ODD_BIT];
         next_st.ctl[EVEN_BIT] = w[EVEN_BIT];
         next_st.ctl[BYTE_BIT] = w[BYTE_BIT];
         next_st.ctl[ROW_BIT] = w[ROW_BIT];
         next_st.ctl[ERASE_BIT] = w[ERASE_BIT];
         if (dual) begin
            next_st.ctl[PVE_BIT] = 1'b0;
         end else if (!(new_otp && new_nv)) begin
            next_st.ctl[OTPL_BIT] = new_otp;
            next_st.ctl[NVL_BIT] = new_nv;
            if (c[OTPL_BIT] || c[NVL_BIT]) begin
               next_st.ctl[PVE_BIT] = w[PVE_BIT];
            end
         end else if (c[OTPL_BIT] || c[NVL_BIT]) begin
            next_st.ctl[PVE_BIT] = w[PVE_BIT];
         end
         if (w == 8'h00) begin
            next_st.ctl = CTL_RESET;
         end
      end
      if (wr && !is_arr && address_i == OFS_GUARD) begin
         next_st.guard = w[GUARD_W-1:0];
      end
      if (wr && !is_arr && address_i == OFS_OPT) begin
         next_st.pump_sel = w[0];
      end
      // Writes with the latch set and the voltage off capture the target; later ones win
      if (wr && (is_arr || address_i == OFS_CFG) &&
          c[NVL_BIT] && !c[PVE_BIT]) begin
         next_st.tgt_valid = 1'b1;
         next_st.tgt_cfg = !is_arr;
         next_st.tgt_idx = idx;
         next_st.tgt_data = w;
      end
      if (!next_st.ctl[NVL_BIT]) begin
         next_st.tgt_valid = 1'b0;
      end

      case (st.eng)
         ENG_IDLE: begin
            if (c[PVE_BIT] && !st.pve_q && c[NVL_BIT] && st.tgt_valid) begin
               next_st.eng = ENG_ARMED;
               next_st.done = 1'b0;
               next_st.op_erase = c[ERASE_BIT];
               if (c[BYTE_BIT] || !c[ERASE_BIT]) begin
                  next_st.walk = st.tgt_idx;
                  next_st.walk_end = st.tgt_idx;
               end else if (c[ROW_BIT]) begin
                  next_st.walk = {st.tgt_idx[AW-1:RB], RB'(0)};
                  next_st.walk_end = {st.tgt_idx[AW-1:RB], {RB{1'b1}}};
               end else begin
                  next_st.walk = '0;
                  next_st.walk_end = '1;
               end
            end
         end
         ENG_ARMED: begin
            // Dropping the voltage before the time is up abandons the op
            if (!c[PVE_BIT]) begin
               next_st.eng = ENG_IDLE;
            end else if (expired) begin
               if (st.tgt_cfg) begin
                  if (!st.guard[GUARD_CFG_BIT]) begin
                     next_st.cfg = st.op_erase ? ERASED :
                                   st.cfg & st.tgt_data;
                  end
                  next_st.eng = ENG_IDLE;
                  next_st.done = 1'b1;
               end else if (st.op_erase) begin
                  next_st.eng = ENG_WALK;
               end else begin
                  next_st.eng = ENG_RD;
               end
            end
         end
         ENG_RD: begin
            mif.addr = st.tgt_idx;
            next_st.eng = ENG_WR;
         end
         ENG_WR: begin
            mif.addr = st.tgt_idx;
            mif.we = c[PVE_BIT] && !guarded(st.guard, st.tgt_idx);
            mif.wdata = mif.rdata & st.tgt_data;
            next_st.eng = ENG_IDLE;
            next_st.done = 1'b1;
         end
         ENG_WALK: begin
            mif.addr = st.walk;
            mif.we = c[PVE_BIT] && !guarded(st.guard, st.walk);
            mif.wdata = ERASED;
            if (st.walk == st.walk_end) begin
               next_st.eng = ENG_IDLE;
               next_st.done = 1'b1;
            end else begin
               next_st.walk = st.walk + 1'b1;
            end
         end
         default: next_st.eng = ENG_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '0;
         st.ctl <= CTL_RESET;
         st.guard <= GUARD_RESET;
         st.cfg <= ERASED;
         st.eng <= ENG_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign waitrequest_o = read_i && st.rd_ph != 2'd2;
   assign readdata_o = st.rdata;
   assign pump_voltage_o = c[PVE_BIT];
   assign otp_program_path_o = c[OTPL_BIT];
   assign nv_program_path_o = c[NVL_BIT];
   assign pump_clock_select_o = st.pump_sel;
   assign single_chip_only_o = st.sec_s2;
   assign setup_cell_o = st.cfg;

   chk_latch_exclusive: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      !(c[OTPL_BIT] && c[NVL_BIT]))
      else $error("both latch bits set");

   chk_voltage_needs_latch: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      $rose(c[PVE_BIT]) |-> ($past(c[OTPL_BIT]) || $past(c[NVL_BIT])))
      else $error("voltage enabled without a latch");

   chk_zero_clears: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      (wr && !is_arr && address_i == OFS_CTL && w == 8'h00)
      |=> (c == CTL_RESET && !pump_voltage_o))
      else $error("zero write left control bits set");

   chk_dual_refused: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      (wr && !is_arr && address_i == OFS_CTL && w[NVL_BIT] &&
       w[PVE_BIT] && !c[NVL_BIT]) |=> (!c[NVL_BIT] && !c[PVE_BIT]))
      else $error("latch and voltage set by one write");

   chk_locked_read: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      (read_i && is_arr && c[NVL_BIT] && st.rd_ph == 2'd1)
      |=> (!waitrequest_o && readdata_o[7:0] == LOCKED_READ))
      else $error("latched array was readable");

   chk_write_needs_voltage: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      mif.we |-> (pump_voltage_o && st.eng != ENG_IDLE &&
                  st.eng != ENG_ARMED))
      else $error("array written without programming voltage");

   chk_byte_over_row: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      (st.eng == ENG_IDLE && $rose(c[PVE_BIT]) && c[NVL_BIT] &&
       st.tgt_valid && c[ERASE_BIT] && c[BYTE_BIT])
      |=> (st.walk == st.walk_end))
      else $error("byte erase covered more than one byte");

   chk_program_clears: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      (st.eng == ENG_WR) |-> (mif.wdata == (mif.rdata & st.tgt_data)))
      else $error("program did not only clear bits");

   chk_program_path: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      (st.eng == ENG_ARMED && expired && !st.op_erase && !st.tgt_cfg)
      |=> st.eng == ENG_RD ##1 st.eng == ENG_WR ##1 st.eng == ENG_IDLE)
      else $error("program sequence broken");
endmodule

// File: test/testbench.sv
/*
 * Self-checking bench for the nonvolatile program/erase controller.
 * Drives the Avalon-MM slave directly and runs program and erase
 * sequences with a short programming time.
 * Assumes the package constants; checks the two read wait states.
 */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import eepc_pkg::*;

   localparam int PC = 20;
   localparam int LIMIT = 20000;

   logic sys_clk_i;
   logic rst_i;
   logic [ADDR_W-1:0] address_i;
   logic read_i;
   logic write_i;
   logic [3:0] byteenable_i;
   logic [DATA_W-1:0] writedata_i;
   logic [DATA_W-1:0] readdata_o;
   logic waitrequest_o;
   logic secure_i;
   logic pump_voltage_o;
   logic otp_program_path_o;
   logic nv_program_path_o;
   logic pump_clock_select_o;
   logic single_chip_only_o;
   logic [7:0] setup_cell_o;
   int n_mismatch;
   int n_tests;
   int cycles;

   eepc_ctrl #(.PROG_CYC(PC), .AW(9)) eepc_ctrl_inst (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .address_i(address_i),
      .read_i(read_i),
      .write_i(write_i),
      .byteenable_i(byteenable_i),
      .writedata_i(writedata_i),
      .readdata_o(readdata_o),
      .waitrequest_o(waitrequest_o),
      .secure_i(secure_i),
      .pump_voltage_o(pump_voltage_o),
      .otp_program_path_o(otp_program_path_o),
      .nv_program_path_o(nv_program_path_o),
      .pump_clock_select_o(pump_clock_select_o),
      .single_chip_only_o(single_chip_only_o),
      .setup_cell_o(setup_cell_o)
   );

   initial begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end

   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // A hung handshake would otherwise stall the run forever
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == LIMIT) begin
         n_mismatch++;
         end_sim();
      end
   end

   task automatic chk_word(input string nm, input logic [31:0] exp,
                           input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic chk_byte(input string nm, input logic [7:0] exp,
                           input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic chk_bit(input string nm, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
      end
   endtask

   // Called just after a rising edge; leaves one idle edge behind it
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      address_i <= a;
      writedata_i <= {24'h000000, d};
      write_i <= 1'b1;
      do @(posedge sys_clk_i); while (waitrequest_o !== 1'b0);
      write_i <= 1'b0;
      @(posedge sys_clk_i);
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a,
                     output logic [DATA_W-1:0] q);
      int n;
      n = 0;
      address_i <= a;
      read_i <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (waitrequest_o !== 1'b0);
      q = readdata_o;
      read_i <= 1'b0;
      @(posedge sys_clk_i);
      chk_word("read wait states", 32'd3, n);
   endtask

   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] exp,
                       input string nm);
      logic [DATA_W-1:0] q;
      rd(a, q);
      chk_word(nm, {24'h000000, exp}, q);
   endtask

   function automatic logic [ADDR_W-1:0] arr(input int i);
      return 12'h800 + 12'(4 * i);
   endfunction

   // Full software sequence: latch, target write, voltage, wait, clear
   task automatic op(input logic [7:0] ctl, input logic [ADDR_W-1:0] a,
                     input logic [7:0] d);
      logic [DATA_W-1:0] s;
      logic seen;
      int k;
      seen = 1'b0;
      wr(OFS_CTL, ctl);
      wr(a, d);
      wr(OFS_CTL, ctl | 8'h01);
      chk_bit("pump_voltage_o on", 1'b1, pump_voltage_o);
      chk_bit("nv_program_path_o", 1'b1, nv_program_path_o);
      for (k = 0; k < 300; k++) begin
         rd(OFS_STAT, s);
         if (s[STAT_BUSY_BIT] === 1'b1) seen = 1'b1;
         if (seen && s[STAT_DONE_BIT] === 1'b1 && s[STAT_BUSY_BIT] === 1'b0)
            break;
      end
      chk_bit("engine completed", 1'b1, seen & s[STAT_DONE_BIT]);
      wr(OFS_CTL, 8'h00);
      chk_bit("pump_voltage_o off", 1'b0, pump_voltage_o);
      chk_bit("nv path off", 1'b0, nv_program_path_o);
   endtask

   initial begin
      rst_i = 1'b1;
      address_i = '0;
      read_i = 1'b0;
      write_i = 1'b0;
      byteenable_i = 4'hf;
      writedata_i = '0;
      secure_i = 1'b0;
      repeat (20) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      @(posedge sys_clk_i);
      rchk(OFS_CTL, 8'h00, "control reset");
      rchk(OFS_GUARD, 8'h1f, "guard reset");
      rchk(OFS_OPT, 8'h00, "option reset");
      chk_byte("setup_cell_o reset", 8'hff, setup_cell_o);
      chk_bit("pump_voltage_o reset", 1'b0, pump_voltage_o);
      wr(12'h020, 8'h55);
      rchk(12'h020, 8'h00, "unmapped read");
      wr(OFS_GUARD, 8'h00);
      rchk(OFS_GUARD, 8'h00, "guard cleared");
      wr(OFS_CTL, 8'h03);
      rchk(OFS_CTL, 8'h00, "latch and voltage together");
      wr(OFS_CTL, 8'h01);
      rchk(OFS_CTL, 8'h00, "voltage without latch");
      wr(OFS_CTL, 8'h22);
      rchk(OFS_CTL, 8'h00, "both latches");
      wr(OFS_CTL, 8'hc0);
      rchk(OFS_CTL, 8'hc0, "row test bits");
      wr(OFS_CTL, 8'h00);
      rchk(OFS_CTL, 8'h00, "cleared control");
      wr(OFS_CTL, 8'h20);
      chk_bit("otp_program_path_o", 1'b1, otp_program_path_o);
      wr(OFS_CTL, 8'h22);
      rchk(OFS_CTL, 8'h20, "second latch refused");
      wr(OFS_CTL, 8'h21);
      chk_bit("pump for otp", 1'b1, pump_voltage_o);
      wr(OFS_CTL, 8'h00);
      chk_bit("otp path off", 1'b0, otp_program_path_o);
      op(8'h02, OFS_CFG, 8'h5a);
      chk_byte("setup cell programmed", 8'h5a, setup_cell_o);
      op(8'h06, arr(7), 8'h00);
      chk_byte("setup cell after bulk", 8'h5a, setup_cell_o);
      rchk(arr(0), 8'hff, "bulk first byte");
      rchk(arr(511), 8'hff, "bulk last byte");
      wr(OFS_CTL, 8'h02);
      rchk(arr(0), 8'h00, "array read blocked");
      rchk(OFS_CFG, 8'h00, "cell read blocked");
      wr(OFS_CTL, 8'h00);
      op(8'h02, arr(5), 8'ha5);
      op(8'h02, arr(16), 8'h3c);
      op(8'h02, arr(17), 8'h11);
      op(8'h02, arr(18), 8'h22);
      rchk(arr(5), 8'ha5, "programmed byte");
      op(8'h1a, arr(5), 8'h0f);
      rchk(arr(5), 8'h05, "program only clears");
      rchk(arr(4), 8'hff, "neighbour untouched");
      op(8'h0e, arr(3), 8'h00);
      rchk(arr(5), 8'hff, "row erased");
      rchk(arr(16), 8'h3c, "next row kept");
      op(8'h16, arr(16), 8'h00);
      rchk(arr(16), 8'hff, "byte erased");
      rchk(arr(17), 8'h11, "byte erase neighbour");
      op(8'h1e, arr(17), 8'h00);
      rchk(arr(17), 8'hff, "byte over row erased");
      rchk(arr(18), 8'h22, "row ignored");
      op(8'h16, OFS_CFG, 8'h00);
      chk_byte("setup cell erased", 8'hff, setup_cell_o);
      // Guarded targets must come through a full sequence untouched
      wr(OFS_GUARD, 8'h11);
      op(8'h02, OFS_CFG, 8'h00);
      chk_byte("guarded setup cell", 8'hff, setup_cell_o);
      op(8'h02, arr(2), 8'h00);
      rchk(arr(2), 8'hff, "guarded quarter");
      wr(OFS_GUARD, 8'h00);
      op(8'h02, OFS_CFG, 8'h3c);
      chk_byte("setup cell reprogrammed", 8'h3c, setup_cell_o);
      byteenable_i <= 4'h0;
      wr(OFS_OPT, 8'h01);
      byteenable_i <= 4'hf;
      rchk(OFS_OPT, 8'h00, "lane 0 disabled");
      wr(OFS_OPT, 8'h01);
      chk_bit("pump_clock_select_o", 1'b1, pump_clock_select_o);
      rchk(OFS_OPT, 8'h01, "option readback");
      secure_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      chk_bit("single_chip_only_o", 1'b1, single_chip_only_o);
      rchk(arr(18), 8'h22, "secure internal read");
      end_sim();
   end
endmodule
